// file: include/cmpreg_consts.svh
// register offsets, field positions, reset values and timing counts of the comparator register bank
`ifndef CMPREG_CONSTS_SVH
`define CMPREG_CONSTS_SVH
`define CMPREG_OFF_CTRL0_ONE 12'h000
`define CMPREG_OFF_CTRL1_ONE 12'h004
`define CMPREG_OFF_CTRL0_TWO 12'h008
`define CMPREG_OFF_CTRL1_TWO 12'h00c
`define CMPREG_OFF_MIRROR 12'h010
`define CMPREG_OFF_IRQ_STAT 12'h014
`define CMPREG_OFF_IRQ_MASK 12'h018
`define CMPREG_BIT_RISE_EN 7
`define CMPREG_BIT_FALL_EN 6
`define CMPREG_BIT_POS_HI 5
`define CMPREG_BIT_POS_LO 4
`define CMPREG_BIT_NEG_SEL 0
`define CMPREG_CTRL1_MASK 8'hf1
`define CMPREG_CTRL0_MASK 8'hbf
`define CMPREG_BIT_CMP_OUT 6
`define CMPREG_BIT_POL 4
`define CMPREG_BIT_ZLF 3
`define CMPREG_RESET_BYTE 8'h00
`define CMPREG_CTRL0_RESET 8'h04
`define CMPREG_CLK_HZ 20000000
`define CMPREG_ZLF_NS 20
`define CMPREG_ZLF_CYCLES ((`CMPREG_ZLF_NS * (`CMPREG_CLK_HZ / 1000000) + 999) / 1000)
`endif

// file: include/cmpreg_pkg.sv
// types shared by the comparator register bank
package cmpreg_pkg;
  typedef enum logic [1:0] {
    CMPREG_POS_PIN = 2'b00,
    CMPREG_POS_DAC = 2'b01,
    CMPREG_POS_FVR = 2'b10,
    CMPREG_POS_GND = 2'b11
  } cmpreg_pos_e;
  typedef struct packed {
    cmpreg_pos_e pos_input_select;
    logic neg_input_select;
  } cmpreg_route_s;
  typedef struct packed {
    logic rise_irq_enable;
    logic fall_irq_enable;
    logic glitch_filter_enable;
    logic invert;
  } cmpreg_edge_cfg_s;
endpackage

// file: core/cmpreg_filter.sv
// zero-latency glitch filter and edge detector for one comparator output
`timescale 1ns/100ps
`include "cmpreg_consts.svh"
module cmpreg_filter
  import cmpreg_pkg::*;
#(
  parameter int HOLD_CYCLES = `CMPREG_ZLF_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic raw_in,
  input wire cmpreg_edge_cfg_s cfg,
  output logic cmp_result,
  output logic edge_event
);
  // hold counter is eight bits wide and must count at least once
  if (HOLD_CYCLES < 1 || HOLD_CYCLES > 255)
  begin : g_hold_range
    $error("cmpreg_filter: HOLD_CYCLES out of range");
  end

  logic sync1_q, sync2_q, out_q, out_d, prev_q, prev_d, evt_q, evt_d;
  logic [7:0] hold_q, hold_d;

  // filter holds a fresh change, then detects edges on the filtered bit
  always_comb
  begin
    logic pol_in;
    pol_in = sync2_q ^ cfg.invert;
    out_d = out_q;
    hold_d = (hold_q != 8'h00) ? hold_q - 8'h01 : 8'h00;
    if (pol_in != out_q && (!cfg.glitch_filter_enable || hold_q == 8'h00))
    begin
      out_d = pol_in;
      hold_d = 8'(HOLD_CYCLES);
    end
    prev_d = out_q;
    evt_d = (cfg.rise_irq_enable && out_q && !prev_q)
      || (cfg.fall_irq_enable && !out_q && prev_q);
  end

  // registers, all clear at reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      out_q <= 1'b0;
      prev_q <= 1'b0;
      hold_q <= 8'h00;
      evt_q <= 1'b0;
    end
    else
    begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      out_q <= out_d;
      prev_q <= prev_d;
      hold_q <= hold_d;
      evt_q <= evt_d;
    end
  end

  assign cmp_result = out_q;
  assign edge_event = evt_q;
endmodule

// file: core/cmpreg_bank.sv
// register bank for two comparators: control, mirror and interrupt flags over apb
`timescale 1ns/100ps
`include "cmpreg_consts.svh"
module cmpreg_bank
  import cmpreg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic raw_result_one,
  input wire logic raw_result_two,
  output cmpreg_route_s route_one,
  output cmpreg_route_s route_two,
  output logic [7:0] ctrl_zero_one,
  output logic [7:0] ctrl_zero_two,
  output logic [1:0] cmp_irq_flag,
  output logic irq
);
  logic [7:0] c0_one_q, c0_one_d, c0_two_q, c0_two_d;
  logic [7:0] c1_one_q, c1_one_d, c1_two_q, c1_two_d;
  logic [1:0] stat_q, stat_d, mask_q, mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic rdy_q, rdy_d, err_q, err_d, irq_q, irq_d;
  logic [1:0] mirror_q, mirror_d;
  cmpreg_route_s rt_one_q, rt_one_d, rt_two_q, rt_two_d;
  logic res_one, res_two, evt_one, evt_two;
  cmpreg_edge_cfg_s cfg_one, cfg_two;

  // byte-wide write merge with implemented-bit mask
  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd,
                                            input logic lane, input logic [7:0] keep);
    merge_byte = lane ? (wd[7:0] & keep) : old;
  endfunction

  // pull routing fields from control one
  function automatic cmpreg_route_s route_of(input logic [7:0] c1);
    route_of.pos_input_select = cmpreg_pos_e'(c1[`CMPREG_BIT_POS_HI:`CMPREG_BIT_POS_LO]);
    route_of.neg_input_select = c1[`CMPREG_BIT_NEG_SEL];
  endfunction

  // edge configuration from both control registers
  function automatic cmpreg_edge_cfg_s cfg_of(input logic [7:0] c0, input logic [7:0] c1);
    cfg_of.rise_irq_enable = c1[`CMPREG_BIT_RISE_EN];
    cfg_of.fall_irq_enable = c1[`CMPREG_BIT_FALL_EN];
    cfg_of.glitch_filter_enable = c0[`CMPREG_BIT_ZLF];
    cfg_of.invert = c0[`CMPREG_BIT_POL];
  endfunction

  assign cfg_one = cfg_of(c0_one_q, c1_one_q);
  assign cfg_two = cfg_of(c0_two_q, c1_two_q);

  // comparator one filter and edge detector
  cmpreg_filter u_filt_one (
    .pclk(pclk),
    .presetn(presetn),
    .raw_in(raw_result_one),
    .cfg(cfg_one),
    .cmp_result(res_one),
    .edge_event(evt_one)
  );

  // comparator two filter and edge detector
  cmpreg_filter u_filt_two (
    .pclk(pclk),
    .presetn(presetn),
    .raw_in(raw_result_two),
    .cfg(cfg_two),
    .cmp_result(res_two),
    .edge_event(evt_two)
  );

  // apb access, register updates and interrupt flags
  always_comb
  begin
    logic wr_go, rd_go, hit;
    logic [1:0] w1c;
    // write lands at the edge where pready is sampled high
    wr_go = psel && penable && pwrite && rdy_q;
    rd_go = psel && penable && !pwrite && !rdy_q;
    c0_one_d = c0_one_q;
    c0_two_d = c0_two_q;
    c1_one_d = c1_one_q;
    c1_two_d = c1_two_q;
    mask_d = mask_q;
    w1c = 2'b00;
    rdata_d = rdata_q;
    hit = 1'b1;
    unique case (paddr)
      `CMPREG_OFF_CTRL0_ONE: rdata_d = {24'h000000, c0_one_q[7], mirror_q[0], c0_one_q[5:0]};
      `CMPREG_OFF_CTRL1_ONE: rdata_d = {24'h000000, c1_one_q};
      `CMPREG_OFF_CTRL0_TWO: rdata_d = {24'h000000, c0_two_q[7], mirror_q[1], c0_two_q[5:0]};
      `CMPREG_OFF_CTRL1_TWO: rdata_d = {24'h000000, c1_two_q};
      `CMPREG_OFF_MIRROR: rdata_d = {30'h00000000, mirror_q};
      `CMPREG_OFF_IRQ_STAT: rdata_d = {30'h00000000, stat_q};
      `CMPREG_OFF_IRQ_MASK: rdata_d = {30'h00000000, mask_q};
      default: hit = 1'b0;
    endcase
    if (!rd_go)
      rdata_d = rdata_q;
    if (rd_go && !hit)
      rdata_d = 32'h00000000;
    if (wr_go)
    begin
      unique case (paddr)
        `CMPREG_OFF_CTRL0_ONE: c0_one_d = merge_byte(c0_one_q, pwdata, pstrb[0], `CMPREG_CTRL0_MASK);
        `CMPREG_OFF_CTRL1_ONE: c1_one_d = merge_byte(c1_one_q, pwdata, pstrb[0], `CMPREG_CTRL1_MASK);
        `CMPREG_OFF_CTRL0_TWO: c0_two_d = merge_byte(c0_two_q, pwdata, pstrb[0], `CMPREG_CTRL0_MASK);
        `CMPREG_OFF_CTRL1_TWO: c1_two_d = merge_byte(c1_two_q, pwdata, pstrb[0], `CMPREG_CTRL1_MASK);
        `CMPREG_OFF_IRQ_STAT: w1c = pstrb[0] ? pwdata[1:0] : 2'b00;
        `CMPREG_OFF_IRQ_MASK: mask_d = pstrb[0] ? pwdata[1:0] : mask_q;
        default: w1c = 2'b00; // mirror and unmapped writes dropped
      endcase
    end
    // set beats clear
    stat_d = (stat_q & ~w1c) | {evt_two, evt_one};
    mirror_d = {res_two, res_one};
    rt_one_d = route_of(c1_one_d);
    rt_two_d = route_of(c1_two_d);
    rdy_d = psel && penable && !rdy_q;
    err_d = psel && penable && !rdy_q && !hit;
    irq_d = |(stat_d & mask_d);
  end

  // state registers, all clear at reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      c0_one_q <= `CMPREG_RESET_BYTE;
      c0_two_q <= `CMPREG_RESET_BYTE;
      c1_one_q <= `CMPREG_RESET_BYTE;
      c1_two_q <= `CMPREG_RESET_BYTE;
      stat_q <= 2'b00;
      mask_q <= 2'b00;
      mirror_q <= 2'b00;
      rdata_q <= 32'h00000000;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      irq_q <= 1'b0;
      rt_one_q <= '0;
      rt_two_q <= '0;
    end
    else
    begin
      c0_one_q <= c0_one_d;
      c0_two_q <= c0_two_d;
      c1_one_q <= c1_one_d;
      c1_two_q <= c1_two_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      mirror_q <= mirror_d;
      rdata_q <= rdata_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
      irq_q <= irq_d;
      rt_one_q <= rt_one_d;
      rt_two_q <= rt_two_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = rdy_q;
  assign pslverr = err_q;
  assign irq = irq_q;
  assign cmp_irq_flag = stat_q;
  assign route_one = rt_one_q;
  assign route_two = rt_two_q;
  assign ctrl_zero_one = c0_one_q;
  assign ctrl_zero_two = c0_two_q;
endmodule

// file: bench/cmpreg_bank_chk.sv
// port-level checks of the comparator register bank
`timescale 1ns/100ps
module cmpreg_bank_chk
  import cmpreg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire cmpreg_route_s route_one,
  input wire cmpreg_route_s route_two,
  input wire logic [1:0] cmp_irq_flag,
  input wire logic irq
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // read data against reserved bits and live routing
  mirror_upper_a: assert property (pready && !pwrite && paddr == 12'h010 |-> prdata[7:2] == 6'h00)
    else $error("mirror high bits set");
  ctrl_reserved_a: assert property (pready && !pwrite && paddr == 12'h004 |-> prdata[3:1] == 3'h0)
    else $error("control reserved bits set");
  route_one_a: assert property (pready && !pwrite && paddr == 12'h004 |-> route_one == {prdata[5:4], prdata[0]})
    else $error("route one differs");
  route_two_a: assert property (pready && !pwrite && paddr == 12'h00c |-> route_two == {prdata[5:4], prdata[0]})
    else $error("route two differs");
  // flags only fall through a status write; irq follows them
  flag_sticky_a: assert property (!(pready && pwrite && paddr == 12'h014) |=> (cmp_irq_flag & $past(cmp_irq_flag)) == $past(cmp_irq_flag))
    else $error("flag lost");
  irq_quiet_a: assert property (cmp_irq_flag == 2'h0 |-> !irq)
    else $error("irq without flag");
  irq_cause_a: assert property ($rose(irq) |-> cmp_irq_flag != 2'h0)
    else $error("irq without cause");
  reset_clear_a: assert property (disable iff (1'h0) !presetn |-> route_one == 3'h0 && route_two == 3'h0 && cmp_irq_flag == 2'h0)
    else $error("state kept in reset");
endmodule
bind cmpreg_bank cmpreg_bank_chk chk_i (.pclk, .presetn, .pwrite, .paddr, .prdata, .pready, .pslverr, .route_one,
  .route_two, .cmp_irq_flag, .irq);

// file: bench/cmpreg_analog_model.sv
// behavioural comparator cores feeding the bank
`timescale 1ns/100ps
module cmpreg_analog_model
(
  input wire logic [7:0] vp_one,
  input wire logic [7:0] vp_two,
  output logic raw_result_one,
  output logic raw_result_two
);
  // each core compares its input with a mid-scale level
  assign raw_result_one = vp_one > 8'h80;
  assign raw_result_two = vp_two > 8'h80;
endmodule

// file: bench/comparator_ctrl_status_regs_tb.sv
// self-checking bench of the comparator register bank
`timescale 1ns/100ps
module comparator_ctrl_status_regs_tb
  import cmpreg_pkg::*;
;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [7:0] vp_one = 8'h0, vp_two = 8'h0, en, c0_one, c0_two;
  logic pready, pslverr, raw_result_one, raw_result_two, irq, ev;
  cmpreg_route_s route_one, route_two;
  logic [1:0] cmp_irq_flag;
  int miscompares = 0, cmp_count = 0;
  always #25 pclk = ~pclk;
  cmpreg_analog_model cores (.vp_one, .vp_two, .raw_result_one, .raw_result_two);
  cmpreg_bank uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready,
    .pslverr, .raw_result_one, .raw_result_two, .route_one, .route_two, .ctrl_zero_one(c0_one), .ctrl_zero_two(c0_two),
    .cmp_irq_flag, .irq);
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task settle;
    repeat (10) @(posedge pclk);
  endtask
  task reset_values;
    for (int a = 0; a < 8; a++)
    begin
      apb(1'h0, 12'(a * 4), 32'h0);
      chk("reset read", 32'h0, rv);
      chk("slave error", a == 7, ev);
    end
  endtask
  task routing;
    for (int j = 0; j < 8; j++)
    begin
      en = {2'h3, j[2:1], 3'h7, j[0]};
      apb(1'h1, 12'h004, {24'h0, en});
      apb(1'h1, 12'h00c, {24'h0, en});
      apb(1'h0, 12'h004, 32'h0);
      chk("ctrl one", {24'h0, en & 8'hf1}, rv);
      chk("route one", {j[2:1], j[0]}, route_one);
      chk("route two", {j[2:1], j[0]}, route_two);
    end
  endtask
  // every enable pair against both edge directions
  task edges;
    logic [7:0] tbl [4] = '{8'h80, 8'h40, 8'hc0, 8'h00};
    apb(1'h1, 12'h018, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'h1, 12'h004, {24'h0, tbl[i]});
      apb(1'h1, 12'h00c, {24'h0, tbl[i]});
      apb(1'h1, 12'h014, 32'h3);
      vp_one <= 8'hff;
      vp_two <= 8'hff;
      settle;
      chk("rise flags", {2{tbl[i][7]}}, cmp_irq_flag);
      chk("irq", tbl[i][7], irq);
      apb(1'h0, 12'h010, 32'h0);
      chk("mirror high", 32'h3, rv);
      apb(1'h1, 12'h014, 32'h3);
      vp_one <= 8'h00;
      vp_two <= 8'h00;
      settle;
      chk("fall flags", {2{tbl[i][6]}}, cmp_irq_flag);
      apb(1'h1, 12'h010, 32'hff);
      apb(1'h0, 12'h010, 32'h0);
      chk("mirror low", 32'h0, rv);
    end
  endtask
  // inverted polarity with filter on: both inputs low read back high
  task polarity;
    apb(1'h1, 12'h000, 32'h18);
    apb(1'h1, 12'h008, 32'h18);
    settle;
    chk("ctrl zero one", 32'h18, c0_one);
    chk("ctrl zero two", 32'h18, c0_two);
    apb(1'h0, 12'h000, 32'h0);
    chk("ctrl zero read", 32'h58, rv);
    apb(1'h0, 12'h010, 32'h0);
    chk("mirror inverted", 32'h3, rv);
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    reset_values;
    routing;
    edges;
    polarity;
    wrap_up;
  end
  // watchdog far beyond the few hundred cycles needed
  initial
  begin
    #100000;
    miscompares++;
    wrap_up;
  end
endmodule
